// file: verilog/emz_pkg.sv
package emz_pkg;

    // Register offsets on the management port
    localparam logic [7:0] EMZ_INPUT_ERROR_MASK_OFS = 8'hEC;
    localparam logic [7:0] EMZ_MISC_ERROR_MASK_OFS = 8'hED;
    localparam logic [7:0] EMZ_ZONE1_OFFSET_OFS = 8'hEE;
    localparam logic [7:0] EMZ_ZONE2_OFFSET_OFS = 8'hEF;

    // Reset values
    localparam logic [7:0] EMZ_INPUT_ERROR_MASK_RST = 8'hFF;
    localparam logic [7:0] EMZ_MISC_ERROR_MASK_RST = 8'h3F;
    localparam logic [7:0] EMZ_ZONE_OFFSET_RST = 8'h00;

    // Writable bits of each register; the rest are reserved
    localparam logic [7:0] EMZ_INPUT_ERROR_MASK_WR = 8'hFF;
    localparam logic [7:0] EMZ_MISC_ERROR_MASK_WR = 8'h3F;
    localparam logic [7:0] EMZ_ZONE_OFFSET_WR = 8'h3F;

    // Field positions in the miscellaneous error mask
    localparam int EMZ_REGULATOR1_HOT_POS = 0;
    localparam int EMZ_REGULATOR2_HOT_POS = 1;
    localparam int EMZ_TERMINATION1_POS = 2;
    localparam int EMZ_TERMINATION2_POS = 3;
    localparam int EMZ_CPU1_DYN_CORE_POS = 4;
    localparam int EMZ_CPU2_DYN_CORE_POS = 5;

    // Sizes
    localparam int EMZ_NUM_INPUTS = 8;
    localparam int EMZ_NUM_ZONES = 2;
    localparam int EMZ_TEMP_W = 8;
    localparam int EMZ_OFFSET_W = 6;

    // Saturation bounds of a corrected temperature, in degrees
    localparam logic [7:0] EMZ_TEMP_MAX = 8'h7F;
    localparam logic [7:0] EMZ_TEMP_MIN = 8'h80;

    // One access from the serial interface engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } emz_reg_req_t;

    // Miscellaneous error events, one bit per regulator, input or CPU
    typedef struct packed {
        logic [1:0] dyn_core;
        logic [1:0] termination;
        logic [1:0] regulator_hot;
    } emz_misc_ev_t;

    // One temperature sample, two's complement degrees
    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } emz_temp_t;

endpackage : emz_pkg

// file: verilog/emz_zone_adjust.sv
`timescale 1ns/10ps
module emz_zone_adjust #(
    parameter int TEMP_W = 8,
    parameter int OFS_W = 6
) (
    input wire logic mclk,
    input wire logic nrst,
    input emz_pkg::emz_temp_t raw,
    input wire logic [OFS_W-1:0] offset,
    output emz_pkg::emz_temp_t adjusted
);
    import emz_pkg::*;

    logic signed [TEMP_W:0] sum; // One guard bit for overflow
    emz_temp_t next_adjusted; // Next registered sample

    ////////////////////////////////////////////////////////////////////
    // Signed add with saturation, applied as the sample is produced
    always_comb begin
        sum = $signed({raw.value[TEMP_W-1], raw.value})
            + $signed({{(TEMP_W + 1 - OFS_W){offset[OFS_W-1]}}, offset});
        next_adjusted.valid = raw.valid;
        next_adjusted.value = adjusted.value;
        if (raw.valid) begin
            // Clamp rather than wrap: a wrapped hot reading would look cold
            if (sum[TEMP_W] != sum[TEMP_W-1]) begin
                next_adjusted.value = sum[TEMP_W] ? EMZ_TEMP_MIN : EMZ_TEMP_MAX;
            end else begin
                next_adjusted.value = sum[TEMP_W-1:0];
            end
        end
    end

    // Register the corrected sample
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            adjusted <= '0;
        end else begin
            adjusted <= next_adjusted;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    adjust_sum_a: assert property (@(posedge mclk) disable iff (!nrst)
        raw.valid && ($signed(raw.value) > -8'sd64)
        && ($signed(raw.value) < 8'sd64)
        |=> adjusted.valid && (adjusted.value == TEMP_W'($past(raw.value)
            + {{(TEMP_W - OFS_W){$past(offset[OFS_W-1])}}, $past(offset)})))
        else $error("corrected temperature is not sample plus offset");
    offset_sign_a: assert property (@(posedge mclk) disable iff (!nrst)
        raw.valid && offset[OFS_W-1] |=>
            $signed(adjusted.value) <= $signed($past(raw.value)))
        else $error("negative offset raised the temperature");
    hold_value_a: assert property (@(posedge mclk) disable iff (!nrst)
        !raw.valid |=> $stable(adjusted.value))
        else $error("corrected temperature changed without a sample");
    neg_offset_c: cover property (@(posedge mclk) disable iff (!nrst)
        raw.valid && offset[OFS_W-1]);

endmodule : emz_zone_adjust

// file: verilog/emz_regs.sv
`timescale 1ns/10ps
module emz_regs #(
    parameter int NUM_INPUTS = emz_pkg::EMZ_NUM_INPUTS,
    parameter int NUM_ZONES = emz_pkg::EMZ_NUM_ZONES
) (
    input wire logic mclk,
    input wire logic nrst,
    input emz_pkg::emz_reg_req_t host_req,
    output logic [7:0] host_rd_data,
    output logic host_rd_valid,
    input wire logic [NUM_INPUTS-1:0] input_level,
    input wire logic [NUM_INPUTS-1:0] input_event,
    output logic [NUM_INPUTS-1:0] input_state,
    output logic [NUM_INPUTS-1:0] input_error_b,
    output logic [NUM_INPUTS-1:0] input_error_h,
    input emz_pkg::emz_misc_ev_t misc_event,
    output emz_pkg::emz_misc_ev_t misc_error,
    input emz_pkg::emz_temp_t [NUM_ZONES-1:0] zone_raw,
    output emz_pkg::emz_temp_t [NUM_ZONES-1:0] zone_temp
);
    import emz_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] input_error_mask; // One bit per general purpose input
    logic [7:0] misc_error_mask; // Regulator, termination, core voltage
    logic [7:0] zone_offset [NUM_ZONES]; // Zone offsets, bits 7:6 reserved
    logic [7:0] next_input_error_mask;
    logic [7:0] next_misc_error_mask;
    logic [7:0] next_zone_offset [NUM_ZONES];
    logic [7:0] next_rd_data;
    logic next_rd_valid;

    // Event paths
    logic [NUM_INPUTS-1:0] next_input_state;
    logic [NUM_INPUTS-1:0] next_input_error;
    emz_misc_ev_t next_misc_error;

    // Hit test for a register offset, shared by write and read decode
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    // Write data limited to the writable bits of a register
    function automatic logic [7:0] merge_write(input logic [7:0] wdata,
                                               input logic [7:0] wmask);
        merge_write = wdata & wmask;
    endfunction : merge_write

    ////////////////////////////////////////////////////////////////////
    // Host writes and read mux
    always_comb begin
        next_input_error_mask = input_error_mask;
        next_misc_error_mask = misc_error_mask;
        for (int z = 0; z < NUM_ZONES; z++) begin
            next_zone_offset[z] = zone_offset[z];
        end
        next_rd_valid = host_req.rd;
        next_rd_data = 8'h00; // Unmapped offsets read as zero
        if (host_req.wr) begin
            if (reg_hit(host_req.addr, EMZ_INPUT_ERROR_MASK_OFS)) begin
                next_input_error_mask = merge_write(host_req.wdata,
                                                    EMZ_INPUT_ERROR_MASK_WR);
            end
            if (reg_hit(host_req.addr, EMZ_MISC_ERROR_MASK_OFS)) begin
                next_misc_error_mask = merge_write(host_req.wdata,
                                                   EMZ_MISC_ERROR_MASK_WR);
            end
            if (reg_hit(host_req.addr, EMZ_ZONE1_OFFSET_OFS)) begin
                next_zone_offset[0] = merge_write(host_req.wdata, EMZ_ZONE_OFFSET_WR);
            end
            if (reg_hit(host_req.addr, EMZ_ZONE2_OFFSET_OFS)) begin
                next_zone_offset[1] = merge_write(host_req.wdata, EMZ_ZONE_OFFSET_WR);
            end
        end
        if (host_req.rd) begin
            // Stored values already hold zeros in reserved bits
            if (reg_hit(host_req.addr, EMZ_INPUT_ERROR_MASK_OFS)) begin
                next_rd_data = input_error_mask;
            end else if (reg_hit(host_req.addr, EMZ_MISC_ERROR_MASK_OFS)) begin
                next_rd_data = misc_error_mask;
            end else if (reg_hit(host_req.addr, EMZ_ZONE1_OFFSET_OFS)) begin
                next_rd_data = zone_offset[0];
            end else if (reg_hit(host_req.addr, EMZ_ZONE2_OFFSET_OFS)) begin
                next_rd_data = zone_offset[1];
            end
        end
    end

    // Register file flops; a write and a read in one cycle see the old value
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            input_error_mask <= EMZ_INPUT_ERROR_MASK_RST;
            misc_error_mask <= EMZ_MISC_ERROR_MASK_RST;
            for (int z = 0; z < NUM_ZONES; z++) begin
                zone_offset[z] <= EMZ_ZONE_OFFSET_RST;
            end
            host_rd_data <= 8'h00;
            host_rd_valid <= 1'b0;
        end else begin
            input_error_mask <= next_input_error_mask;
            misc_error_mask <= next_misc_error_mask;
            for (int z = 0; z < NUM_ZONES; z++) begin
                zone_offset[z] <= next_zone_offset[z];
            end
            host_rd_data <= next_rd_data;
            host_rd_valid <= next_rd_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Error event masking
    always_comb begin
        next_input_state = input_level;
        next_input_error = input_event & ~input_error_mask[NUM_INPUTS-1:0];
        next_misc_error.regulator_hot = misc_event.regulator_hot
            & ~misc_error_mask[EMZ_REGULATOR2_HOT_POS:EMZ_REGULATOR1_HOT_POS];
        next_misc_error.termination = misc_event.termination
            & ~misc_error_mask[EMZ_TERMINATION2_POS:EMZ_TERMINATION1_POS];
        next_misc_error.dyn_core = misc_event.dyn_core
            & ~misc_error_mask[EMZ_CPU2_DYN_CORE_POS:EMZ_CPU1_DYN_CORE_POS];
    end

    // Both status views take the same masked event
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            input_state <= '0;
            input_error_b <= '0;
            input_error_h <= '0;
            misc_error <= '0;
        end else begin
            input_state <= next_input_state;
            input_error_b <= next_input_error;
            input_error_h <= next_input_error;
            misc_error <= next_misc_error;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-zone offset correction; zone_temp is the only temperature
    // handed on, so no consumer can bypass the offset
    generate
        for (genvar z = 0; z < NUM_ZONES; z++) begin : g_zone
            emz_zone_adjust #(
                .TEMP_W(EMZ_TEMP_W),
                .OFS_W(EMZ_OFFSET_W)
            ) u_adjust (
                .mclk(mclk),
                .nrst(nrst),
                .raw(zone_raw[z]),
                .offset(zone_offset[z][EMZ_OFFSET_W-1:0]),
                .adjusted(zone_temp[z])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Checks
    mask_reset_a: assert property (@(posedge mclk)
        $rose(nrst) |-> input_error_mask == EMZ_INPUT_ERROR_MASK_RST
            && misc_error_mask == EMZ_MISC_ERROR_MASK_RST)
        else $error("mask registers not at reset value");
    input_block_a: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 ((input_error_b | input_error_h) & $past(input_error_mask)) == '0)
        else $error("masked input raised an error status");
    input_pass_a: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 input_error_b == ($past(input_event) & ~$past(input_error_mask))
            && input_error_h == input_error_b)
        else $error("unmasked input event lost");
    state_live_a: assert property (@(posedge mclk) disable iff (!nrst)
        ##1 input_state == $past(input_level))
        else $error("input state does not follow the input level");
    misc_block_a: assert property (@(posedge mclk) disable iff (!nrst)
        misc_error_mask[1:0] == 2'h3 |=> misc_error.regulator_hot == 2'h0)
        else $error("masked regulator event passed");
    dyn_core_a: assert property (@(posedge mclk) disable iff (!nrst)
        misc_event.dyn_core[0] && !misc_error_mask[4] |=> misc_error.dyn_core[0])
        else $error("unmasked core voltage event lost");
    zone_reserved_a: assert property (@(posedge mclk) disable iff (!nrst)
        host_req.wr && host_req.addr == 8'hEE |=> zone_offset[0]
            == ($past(host_req.wdata) & 8'h3F))
        else $error("zone offset write not limited to six bits");
    read_reserved_a: assert property (@(posedge mclk) disable iff (!nrst)
        host_req.rd && host_req.addr == 8'hED |=> host_rd_valid
            && host_rd_data[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
    // Fully masked groups must stay silent whatever the events do
    term_block_a: assert property (@(posedge mclk) disable iff (!nrst)
        misc_error_mask[3:2] == 2'h3 |=> misc_error.termination == 2'h0)
        else $error("masked termination event passed");
    dyn_block_a: assert property (@(posedge mclk) disable iff (!nrst)
        misc_error_mask[5:4] == 2'h3 |=> misc_error.dyn_core == 2'h0)
        else $error("masked core voltage event passed");
    // Offsets must come back to zero on every reset, mid-run ones too
    zone_reset_a: assert property (@(posedge mclk)
        $rose(nrst) |-> zone_offset[0] == EMZ_ZONE_OFFSET_RST
            && zone_offset[1] == EMZ_ZONE_OFFSET_RST)
        else $error("zone offsets not at reset value");
    // Writes keep only the defined fields; reserved bits stay zero
    misc_write_a: assert property (@(posedge mclk) disable iff (!nrst)
        host_req.wr && host_req.addr == EMZ_MISC_ERROR_MASK_OFS |=> misc_error_mask
            == ($past(host_req.wdata) & EMZ_MISC_ERROR_MASK_WR))
        else $error("misc mask write not limited to six bits");
    zone2_write_a: assert property (@(posedge mclk) disable iff (!nrst)
        host_req.wr && host_req.addr == EMZ_ZONE2_OFFSET_OFS |=> zone_offset[1]
            == ($past(host_req.wdata) & EMZ_ZONE_OFFSET_WR))
        else $error("zone 2 offset write not limited to six bits");
    input_write_a: assert property (@(posedge mclk) disable iff (!nrst)
        host_req.wr && host_req.addr == EMZ_INPUT_ERROR_MASK_OFS |=> input_error_mask
            == $past(host_req.wdata))
        else $error("input mask write lost");
    write_mask_c: cover property (@(posedge mclk) disable iff (!nrst)
        host_req.wr && host_req.addr == 8'hEC ##1 host_req.rd && host_req.addr == 8'hEC);
    event_pass_c: cover property (@(posedge mclk) disable iff (!nrst) |input_error_b);
    zone_sample_c: cover property (@(posedge mclk) disable iff (!nrst)
        zone_raw[1].valid && zone_offset[1] != 8'h00);

endmodule : emz_regs

// file: testbench/emz_host_model.sv
`timescale 1ns/10ps
module emz_host_model (
    input wire logic mclk,
    output emz_pkg::emz_reg_req_t host_req,
    input wire logic [7:0] host_rd_data,
    input wire logic host_rd_valid
);
    import emz_pkg::*;

    // Bus starts idle
    initial host_req = '0;

    ////////////////////////////////////////////////////////////////////////
    // One write byte; idle address and data show the inverse, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        host_req <= '{1'b1, 1'b0, a, d};
        @(negedge mclk);
        host_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr

    // One read byte; answer sampled in the cycle it stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge mclk);
        host_req <= '{1'b0, 1'b1, a, ~a};
        @(negedge mclk);
        host_req <= '{1'b0, 1'b0, ~a, a};
        d = host_rd_data;
        v = host_rd_valid;
    endtask : rd
endmodule : emz_host_model

// file: testbench/tb_error_mask_and_zone_offset_regs.sv
`timescale 1ns/10ps
module tb_error_mask_and_zone_offset_regs;
    import emz_pkg::*;

    logic mclk = 1'b0; // 40 MHz
    logic nrst = 1'b0; // Active low reset
    emz_reg_req_t host_req;
    logic [7:0] host_rd_data;
    logic host_rd_valid;
    logic [7:0] input_level = 8'h00;
    logic [7:0] input_event = 8'h00;
    logic [7:0] input_state, input_error_b, input_error_h;
    emz_misc_ev_t misc_event = '0;
    emz_misc_ev_t misc_error;
    emz_temp_t [1:0] zone_raw = '0;
    emz_temp_t [1:0] zone_temp;
    int num_errors = 0;
    int n_compared = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and host
    always #12.5 mclk = ~mclk;

    emz_regs dut_u (.mclk(mclk), .nrst(nrst), .host_req(host_req),
        .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid),
        .input_level(input_level), .input_event(input_event),
        .input_state(input_state), .input_error_b(input_error_b),
        .input_error_h(input_error_h), .misc_event(misc_event),
        .misc_error(misc_error), .zone_raw(zone_raw), .zone_temp(zone_temp));

    emz_host_model host_u (.mclk(mclk), .host_req(host_req),
        .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid));

    ////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Read one register and judge both the strobe and the byte
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        host_u.rd(a, d, v);
        chk({7'h00, v}, 8'h01, "read valid");
        chk(d, e, "read data");
    endtask : rd_chk

    // Expected corrected sample; saturates rather than wraps
    function automatic logic [7:0] corr(input logic [7:0] r, input logic [5:0] o);
        int s;
        s = int'($signed(r)) + int'($signed(o));
        if (s > 127) return 8'h7F;
        if (s < -128) return 8'h80;
        return 8'(s);
    endfunction : corr

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_values;
        rd_chk(EMZ_INPUT_ERROR_MASK_OFS, 8'hFF);
        rd_chk(EMZ_MISC_ERROR_MASK_OFS, 8'h3F);
        rd_chk(EMZ_ZONE1_OFFSET_OFS, 8'h00);
        rd_chk(EMZ_ZONE2_OFFSET_OFS, 8'h00);
        rd_chk(8'hEB, 8'h00);
    endtask : t_reset_values

    // Reserved bits dropped, unmapped write harmless, mid-run reset restores
    task automatic t_reserved;
        host_u.wr(EMZ_MISC_ERROR_MASK_OFS, 8'hFF);
        rd_chk(EMZ_MISC_ERROR_MASK_OFS, 8'h3F);
        host_u.wr(EMZ_ZONE1_OFFSET_OFS, 8'hE1);
        rd_chk(EMZ_ZONE1_OFFSET_OFS, 8'h21);
        host_u.wr(EMZ_ZONE2_OFFSET_OFS, 8'hDA);
        host_u.wr(8'hF0, 8'h55);
        rd_chk(EMZ_ZONE2_OFFSET_OFS, 8'h1A);
        host_u.wr(EMZ_INPUT_ERROR_MASK_OFS, 8'h5A);
        rd_chk(EMZ_INPUT_ERROR_MASK_OFS, 8'h5A);
        @(negedge mclk);
        nrst = 1'b0;
        @(negedge mclk);
        nrst = 1'b1;
        rd_chk(EMZ_INPUT_ERROR_MASK_OFS, 8'hFF);
        rd_chk(EMZ_ZONE1_OFFSET_OFS, 8'h00);
        rd_chk(EMZ_ZONE2_OFFSET_OFS, 8'h00);
    endtask : t_reserved

    // Default all-masked, then none, then half; state is never masked
    task automatic t_input_mask;
        logic [7:0] m;
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'h0F;
            if (i > 0) begin
                host_u.wr(EMZ_INPUT_ERROR_MASK_OFS, m);
            end
            @(negedge mclk);
            input_event = 8'hA5;
            input_level = m ^ 8'h3C;
            @(negedge mclk);
            chk(input_error_b, 8'hA5 & ~m, "error b");
            chk(input_error_h, 8'hA5 & ~m, "error h");
            chk(input_state, m ^ 8'h3C, "state");
        end
        input_event = 8'h00;
    endtask : t_input_mask

    // Each misc mask bit cleared alone lets only its own event through
    task automatic t_misc_mask;
        for (int i = 0; i < 6; i++) begin
            host_u.wr(EMZ_MISC_ERROR_MASK_OFS, 8'h3F ^ (8'h01 << i));
            @(negedge mclk);
            misc_event = 6'h3F;
            @(negedge mclk);
            chk({2'h0, misc_error}, 8'h01 << i, "misc error");
        end
        misc_event = '0;
    endtask : t_misc_mask

    // Offsets at both range ends, with saturation, on alternating zones
    task automatic t_zone;
        logic [7:0] ofs [5] = '{8'h3E, 8'h1F, 8'h20, 8'h20, 8'h1F};
        logic [7:0] raw [5] = '{8'h19, 8'h70, 8'h90, 8'h00, 8'h05};
        for (int i = 0; i < 5; i++) begin
            host_u.wr(i[0] ? EMZ_ZONE2_OFFSET_OFS : EMZ_ZONE1_OFFSET_OFS, ofs[i]);
            @(negedge mclk);
            zone_raw[i[0]] = '{1'b1, raw[i]};
            @(negedge mclk);
            zone_raw[i[0]] = '{1'b0, ~raw[i]};
            chk({7'h00, zone_temp[i[0]].valid}, 8'h01, "zone valid");
            chk(zone_temp[i[0]].value, corr(raw[i], ofs[i][5:0]), "zone value");
            @(negedge mclk);
            chk({7'h00, zone_temp[i[0]].valid}, 8'h00, "zone pulse");
            chk(zone_temp[i[0]].value, corr(raw[i], ofs[i][5:0]), "zone hold");
        end
    endtask : t_zone

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic close_out;
        $display("Errors %0d compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // Whole run is about 110 cycles; this is over thirty times that
    initial begin
        repeat (4000) @(posedge mclk);
        num_errors++;
        $display("FAIL %0t watchdog expired", $time);
        close_out();
    end

    // Main sequence
    initial begin
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        t_reset_values();
        t_reserved();
        t_input_mask();
        t_misc_mask();
        t_zone();
        close_out();
    end
endmodule : tb_error_mask_and_zone_offset_regs
